// ==== hw/isd_pkg.sv ====
/*
  Shared constants and types for the instruction execute block.
  Assumes one core clock domain and an active-low asynchronous reset.
*/
package isd_pkg;

  // --------------------------------------------------------------------
  // widths
  // --------------------------------------------------------------------
  localparam int ISD_DATA_W = 8;
  localparam int ISD_ADDR_W = 7;
  localparam int ISD_LIT_W = 11;
  localparam int ISD_PC_W = 13;
  localparam int ISD_LATCH_W = 8;

  // --------------------------------------------------------------------
  // field positions
  // --------------------------------------------------------------------
  localparam int ISD_LATCH_HI = 4;
  localparam int ISD_LATCH_LO = 3;

  // --------------------------------------------------------------------
  // values
  // --------------------------------------------------------------------
  localparam logic [7:0] ISD_ZERO = 8'h00;
  localparam logic [7:0] ISD_ONE = 8'h01;
  localparam logic [7:0] ISD_ACC_RESET = 8'h00;
  localparam logic ISD_ZFLAG_RESET = 1'b0;
  localparam logic [12:0] ISD_PC_RESET = 13'h0000;
  localparam logic [6:0] ISD_ADDR_RESET = 7'h00;

  // --------------------------------------------------------------------
  // operations
  // --------------------------------------------------------------------
  typedef enum logic [2:0] {
    clear_accumulator_op = 3'h0,
    decrement_skip_zero_op = 3'h1,
    increment_skip_zero_op = 3'h2,
    unconditional_branch_op = 3'h3,
    or_literal_op = 3'h4,
    increment_register_op = 3'h5,
    no_op = 3'h7
  } isd_op_t;

  // --------------------------------------------------------------------
  // sequencer states, one-hot
  // --------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_EXEC = 3'b001,
    ST_SKIP = 3'b010,
    ST_BRANCH = 3'b100
  } isd_state_t;

endpackage

// ==== hw/isd_alu_if.sv ====
/*
  Carrier between the execute sequencer and its arithmetic unit.
  Assumes both ends sit in the same clock domain; purely combinational.
*/
`timescale 1ns/10ps
interface isd_alu_if;
  import isd_pkg::*;
  isd_op_t op;
  logic [7:0] operand_f;
  logic [7:0] acc;
  logic [7:0] literal;
  logic dest;
  logic [7:0] result;
  logic zero;
  logic affects_z;
  logic write_acc;
  logic write_file;
  logic skip;
  logic branch;

  modport core (output op, operand_f, acc, literal, dest,
                input result, zero, affects_z, write_acc, write_file, skip, branch);
  modport alu (input op, operand_f, acc, literal, dest,
               output result, zero, affects_z, write_acc, write_file, skip, branch);
endinterface

// ==== hw/isd_alu.sv ====
/*
  Arithmetic and decode unit: result, flag effect, destination and skip.
  Assumes operands are stable for the cycle in which they are used.
*/
`timescale 1ns/10ps
module isd_alu
  import isd_pkg::*;
(
  isd_alu_if.alu alu
);

  // --------------------------------------------------------------------
  // decode
  // --------------------------------------------------------------------
  function automatic logic uses_dest(input isd_op_t op);
    uses_dest = (op == decrement_skip_zero_op) || (op == increment_skip_zero_op) ||
                (op == increment_register_op);
  endfunction

  wire is_clear = (alu.op == clear_accumulator_op);
  wire is_dec = (alu.op == decrement_skip_zero_op);
  wire is_inc = (alu.op == increment_skip_zero_op) || (alu.op == increment_register_op);
  wire is_or = (alu.op == or_literal_op);
  wire to_file = uses_dest(alu.op) && alu.dest;
  wire [7:0] inc_value = 8'(alu.operand_f + ISD_ONE); // RULE12
  wire [7:0] dec_value = 8'(alu.operand_f - ISD_ONE); // RULE12

  // --------------------------------------------------------------------
  // results
  // --------------------------------------------------------------------
  assign alu.result = is_clear ? ISD_ZERO : // RULE1
                      is_dec ? dec_value : // RULE3
                      is_inc ? inc_value : // RULE5 RULE10
                      is_or ? (alu.acc | alu.literal) : // RULE9
                      ISD_ZERO;
  assign alu.zero = (alu.result == ISD_ZERO); // RULE11
  assign alu.affects_z = is_clear || is_or || (alu.op == increment_register_op);
  assign alu.write_file = to_file; // RULE2
  assign alu.write_acc = is_clear || is_or || (uses_dest(alu.op) && !alu.dest); // RULE2
  assign alu.skip = ((alu.op == decrement_skip_zero_op) ||
                     (alu.op == increment_skip_zero_op)) && alu.zero; // RULE4 RULE6
  assign alu.branch = (alu.op == unconditional_branch_op);

endmodule

// ==== hw/isd_exec.sv ====
/*
  Execute stage for a small instruction subset: accumulator, zero flag,
  file-register write port, skip handling and branch target.
  Assumes the fetch stage offers one decoded instruction with op_valid,
  that file_rdata returns the register selected by op_addr in the same
  cycle, and that all inputs are synchronous to clock.
*/
`timescale 1ns/10ps
// Summary of operation
// RULE1: clearing the accumulator loads zero into it and sets the zero flag.
// RULE2: a destination bit of 0 sends the result to the accumulator, 1 to the file register.
// RULE3: decrement-and-skip subtracts one from file register 0..127 and leaves flags alone.
// RULE4: a zero decrement-and-skip result discards the next instruction for one no-op cycle.
// RULE5: increment-and-skip adds one to the file register and leaves flags alone.
// RULE6: a zero increment-and-skip result replaces the next instruction with a no-op.
// RULE7: the branch loads its 11-bit target into pc 10:0 and latch bits 4:3 into pc 12:11.
// RULE8: the branch takes two cycles, pushes no return address and touches no flag.
// RULE9: or-literal ors the accumulator with an 8-bit literal and updates the zero flag.
// RULE10: plain increment adds one, routes by destination, updates zero and never skips.
// RULE11: where zero is affected it is set for a zero result and cleared otherwise.
// RULE12: increment and decrement wrap modulo 256.
module isd_exec
  import isd_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic op_valid,
  input wire logic [2:0] op_code,
  input wire logic op_dest,
  input wire logic [6:0] op_addr,
  input wire logic [10:0] op_literal,
  input wire logic [7:0] pc_high_latch,
  input wire logic [7:0] file_rdata,
  output logic op_ready,
  output logic skip_nop,
  output logic [6:0] file_addr,
  output logic [6:0] file_waddr,
  output logic [7:0] file_wdata,
  output logic file_we,
  output logic [7:0] acc,
  output logic zero_flag,
  output logic pc_load,
  output logic [12:0] pc_target,
  output logic stack_push
);

  // --------------------------------------------------------------------
  // arithmetic unit
  // --------------------------------------------------------------------
  isd_alu_if alu_bus();
  isd_state_t state;
  isd_state_t next_state;

  wire accepted = op_valid && op_ready;
  wire isd_op_t cur_op = accepted ? isd_op_t'(op_code) : no_op;

  assign alu_bus.op = cur_op;
  assign alu_bus.operand_f = file_rdata;
  assign alu_bus.acc = acc;
  assign alu_bus.literal = op_literal[7:0];
  assign alu_bus.dest = op_dest;

  isd_alu isd_alu_i (
    .alu(alu_bus)
  );

  // --------------------------------------------------------------------
  // sequencer
  // --------------------------------------------------------------------
  assign op_ready = (state == ST_EXEC);
  assign skip_nop = (state == ST_SKIP); // RULE4 RULE6
  assign file_addr = op_addr;
  assign stack_push = 1'b0; // RULE8

  always_comb begin
    case (state)
      ST_EXEC: begin
        if (alu_bus.branch) begin
          next_state = ST_BRANCH; // RULE8
        end else if (alu_bus.skip) begin
          next_state = ST_SKIP; // RULE4 RULE6
        end else begin
          next_state = ST_EXEC;
        end
      end
      ST_SKIP: next_state = ST_EXEC;
      ST_BRANCH: next_state = ST_EXEC;
      default: next_state = ST_EXEC;
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state <= ST_EXEC;
    end else begin
      state <= next_state;
    end
  end

  // --------------------------------------------------------------------
  // accumulator and flag
  // --------------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      acc <= ISD_ACC_RESET;
      zero_flag <= ISD_ZFLAG_RESET;
    end else begin
      if (alu_bus.write_acc) begin
        acc <= alu_bus.result; // RULE1 RULE2 RULE9
      end
      if (alu_bus.affects_z) begin
        zero_flag <= alu_bus.zero; // RULE11
      end
    end
  end

  // --------------------------------------------------------------------
  // file write port
  // --------------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      file_we <= 1'b0;
      file_waddr <= ISD_ADDR_RESET;
      file_wdata <= ISD_ZERO;
    end else begin
      file_we <= alu_bus.write_file; // RULE2
      if (alu_bus.write_file) begin
        file_waddr <= op_addr;
        file_wdata <= alu_bus.result;
      end
    end
  end

  // --------------------------------------------------------------------
  // branch
  // --------------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pc_load <= 1'b0;
      pc_target <= ISD_PC_RESET;
    end else begin
      pc_load <= alu_bus.branch;
      if (alu_bus.branch) begin
        pc_target <= {pc_high_latch[ISD_LATCH_HI:ISD_LATCH_LO], op_literal}; // RULE7
      end
    end
  end

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  wire take_clear = accepted && (op_code == clear_accumulator_op);
  wire take_dec = accepted && (op_code == decrement_skip_zero_op);
  wire take_incs = accepted && (op_code == increment_skip_zero_op);
  wire take_br = accepted && (op_code == unconditional_branch_op);
  wire take_or = accepted && (op_code == or_literal_op);
  wire take_inc = accepted && (op_code == increment_register_op);

  sequence s_nop_slot;
    skip_nop && !op_ready ##1 op_ready && !skip_nop;
  endsequence

  sequence s_branch_slot;
    !op_ready && !stack_push && $stable(zero_flag) ##1 op_ready;
  endsequence

  property p_clear;
    take_clear |=> acc == ISD_ZERO && zero_flag;
  endproperty
  a_clear: assert property (p_clear) else $error("clear did not zero acc"); // RULE1

  property p_dest;
    take_inc |=> (file_we == $past(op_dest)) && ($past(op_dest) ? acc == $past(acc) :
                 acc == 8'($past(file_rdata) + ISD_ONE));
  endproperty
  a_dest: assert property (p_dest) else $error("destination routing wrong"); // RULE2

  property p_dec;
    take_dec |=> (($past(op_dest) ? file_wdata : acc) == 8'($past(file_rdata) - ISD_ONE))
                 && $stable(zero_flag);
  endproperty
  a_dec: assert property (p_dec) else $error("decrement result or flag wrong"); // RULE3

  property p_dec_skip;
    take_dec && file_rdata == ISD_ONE |=> s_nop_slot;
  endproperty
  a_dec_skip: assert property (p_dec_skip) else $error("decrement skip missing"); // RULE4

  property p_dec_noskip;
    take_dec && file_rdata != ISD_ONE |=> op_ready && !skip_nop;
  endproperty
  a_dec_noskip: assert property (p_dec_noskip) else $error("spurious decrement skip"); // RULE4

  property p_incs;
    take_incs |=> $stable(zero_flag) &&
                  (($past(op_dest) ? file_wdata : acc) == 8'($past(file_rdata) + ISD_ONE));
  endproperty
  a_incs: assert property (p_incs) else $error("increment skip result wrong"); // RULE5

  property p_incs_skip;
    take_incs && file_rdata == 8'hff |=> s_nop_slot;
  endproperty
  a_incs_skip: assert property (p_incs_skip) else $error("increment skip missing"); // RULE6 RULE12

  property p_branch;
    take_br |=> pc_load && pc_target == {$past(pc_high_latch[4:3]), $past(op_literal)};
  endproperty
  a_branch: assert property (p_branch) else $error("branch target wrong"); // RULE7

  property p_branch_cycles;
    take_br |=> s_branch_slot;
  endproperty
  a_branch_cycles: assert property (p_branch_cycles) else $error("branch timing wrong"); // RULE8

  property p_or;
    take_or |=> acc == ($past(acc) | $past(op_literal[7:0])) && zero_flag == (acc == ISD_ZERO);
  endproperty
  a_or: assert property (p_or) else $error("or literal wrong"); // RULE9 RULE11

  property p_inc;
    take_inc |=> op_ready && zero_flag == ($past(file_rdata) == 8'hff);
  endproperty
  a_inc: assert property (p_inc) else $error("increment flag or skip wrong"); // RULE10 RULE11

endmodule

// ==== dv/test_incdec_skip_branch_exec.sv ====
/*
  Self-checking bench for the execute block: drives the instruction port
  and stands in for the register file read data itself.
  Assumes the design packages are compiled first; one 200 MHz clock.
*/
`timescale 1ns/10ps
module test_incdec_skip_branch_exec
  import isd_pkg::*;
;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic op_valid = 1'b0;
  logic [2:0] op_code = 3'h7;
  logic op_dest = 1'b0;
  logic [6:0] op_addr = 7'h00;
  logic [10:0] op_literal = 11'h000;
  logic [7:0] pc_high_latch = 8'h00;
  logic [7:0] file_rdata = 8'h00;
  logic op_ready, skip_nop, file_we, zero_flag, pc_load, stack_push;
  logic [6:0] file_addr, file_waddr;
  logic [7:0] file_wdata, acc;
  logic [12:0] pc_target;
  int n_mismatch = 0;
  int compares = 0;
  int cycles = 0;

  always #2.5 clock = ~clock;

  isd_exec isd_exec_i (.clock(clock), .resetn(resetn), .op_valid(op_valid),
    .op_code(op_code), .op_dest(op_dest), .op_addr(op_addr), .op_literal(op_literal),
    .pc_high_latch(pc_high_latch), .file_rdata(file_rdata), .op_ready(op_ready),
    .skip_nop(skip_nop), .file_addr(file_addr), .file_waddr(file_waddr),
    .file_wdata(file_wdata), .file_we(file_we), .acc(acc), .zero_flag(zero_flag),
    .pc_load(pc_load), .pc_target(pc_target), .stack_push(stack_push));

  // --------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------
  task automatic chk(input logic [12:0] got, input logic [12:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // offers one instruction for one cycle, returns at the next falling edge without checking op_ready
  task automatic issue(input logic [2:0] c, input logic d, input logic [6:0] a,
                       input logic [10:0] k, input logic [7:0] r);
    @(negedge clock);
    op_valid = 1'b1;
    op_code = c;
    op_dest = d;
    op_addr = a;
    op_literal = k;
    file_rdata = r;
    @(negedge clock);
    op_valid = 1'b0;
  endtask

  task automatic complete_run;
    $display("counts: %0d compares, %0d mismatches", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // --------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------
  task automatic t_clear_or;
    issue(or_literal_op, 1'b0, 7'h00, 11'h05a, 8'h00);
    chk(acc, 13'h05a, "or acc");
    chk(zero_flag, 13'h0, "or zero");
    issue(clear_accumulator_op, 1'b0, 7'h00, 11'h000, 8'h00);
    chk(acc, 13'h000, "clear acc");
    chk(zero_flag, 13'h1, "clear zero");
    issue(or_literal_op, 1'b0, 7'h00, 11'h700, 8'h00);
    chk(acc, 13'h000, "or upper literal bits ignored");
    chk(zero_flag, 13'h1, "or zero result");
    issue(or_literal_op, 1'b0, 7'h00, 11'h0ff, 8'h00);
    chk(acc, 13'h0ff, "or full literal");
    chk(zero_flag, 13'h0, "or nonzero");
    $display("test clear_or done");
  endtask

  task automatic t_incr;
    issue(increment_register_op, 1'b0, 7'h11, 11'h000, 8'hff);
    chk(acc, 13'h000, "inc wrap to acc");
    chk(zero_flag, 13'h1, "inc zero");
    chk(file_we, 13'h0, "inc dest0 no write");
    chk(skip_nop, 13'h0, "inc never skips");
    issue(increment_register_op, 1'b1, 7'h7f, 11'h000, 8'h41);
    chk(file_we, 13'h1, "inc write");
    chk(file_waddr, 13'h07f, "inc waddr");
    chk(file_addr, 13'h07f, "inc read addr");
    chk(file_wdata, 13'h042, "inc wdata");
    chk(acc, 13'h000, "inc dest1 acc kept");
    chk(zero_flag, 13'h0, "inc nonzero");
    chk(op_ready, 13'h1, "inc no stall");
    $display("test incr done");
  endtask

  task automatic t_dec_skip;
    issue(clear_accumulator_op, 1'b0, 7'h00, 11'h000, 8'h00);
    // driven by hand so the skipped slot is offered with no gap
    @(negedge clock);
    op_valid = 1'b1;
    op_code = decrement_skip_zero_op;
    op_dest = 1'b1;
    op_addr = 7'h25;
    file_rdata = 8'h01;
    @(negedge clock);
    chk(file_we, 13'h1, "decsz write");
    chk(file_waddr, 13'h025, "decsz waddr");
    chk(file_wdata, 13'h000, "decsz wdata");
    chk(skip_nop, 13'h1, "decsz skip");
    chk(op_ready, 13'h0, "decsz stall");
    chk(zero_flag, 13'h1, "decsz flag kept");
    op_code = increment_register_op;
    op_dest = 1'b0;
    file_rdata = 8'h33;
    @(negedge clock);
    op_valid = 1'b0;
    chk(acc, 13'h000, "skipped op discarded");
    chk(skip_nop, 13'h0, "skip one cycle");
    chk(op_ready, 13'h1, "ready after skip");
    issue(decrement_skip_zero_op, 1'b0, 7'h00, 11'h000, 8'h00);
    chk(acc, 13'h0ff, "decsz wrap to acc");
    chk(skip_nop, 13'h0, "decsz no skip");
    chk(file_we, 13'h0, "decsz dest0");
    chk(zero_flag, 13'h1, "decsz flag kept");
    $display("test dec_skip done");
  endtask

  task automatic t_inc_skip;
    issue(or_literal_op, 1'b0, 7'h00, 11'h001, 8'h00);
    issue(increment_skip_zero_op, 1'b0, 7'h03, 11'h000, 8'hff);
    chk(acc, 13'h000, "incsz wrap to acc");
    chk(zero_flag, 13'h0, "incsz flag kept");
    chk(skip_nop, 13'h1, "incsz skip");
    chk(op_ready, 13'h0, "incsz stall");
    issue(increment_skip_zero_op, 1'b1, 7'h10, 11'h000, 8'h10);
    chk(file_wdata, 13'h011, "incsz wdata");
    chk(file_we, 13'h1, "incsz write");
    chk(skip_nop, 13'h0, "incsz no skip");
    $display("test inc_skip done");
  endtask

  task automatic t_branch;
    pc_high_latch = 8'hf7;
    issue(unconditional_branch_op, 1'b0, 7'h00, 11'h7ff, 8'h00);
    chk(pc_load, 13'h1, "branch load");
    chk(pc_target, 13'h17ff, "branch target");
    chk(op_ready, 13'h0, "branch two cycles");
    chk(stack_push, 13'h0, "branch no push");
    chk(zero_flag, 13'h0, "branch flag kept");
    @(negedge clock);
    chk(pc_load, 13'h0, "branch pulse");
    pc_high_latch = 8'h08;
    issue(unconditional_branch_op, 1'b0, 7'h00, 11'h000, 8'h00);
    chk(pc_target, 13'h0800, "branch low latch bit");
    $display("test branch done");
  endtask

  // --------------------------------------------------------------------
  // main sequence and hang guard
  // --------------------------------------------------------------------
  always @(posedge clock) begin
    cycles++;
    if (cycles == 2000) begin
      n_mismatch++;
      complete_run;
    end
  end

  initial begin
    repeat (10) @(negedge clock);
    resetn = 1'b1;
    chk(acc, 13'h000, "reset acc");
    chk(op_ready, 13'h1, "reset ready");
    t_clear_or;
    t_incr;
    t_dec_skip;
    t_inc_skip;
    t_branch;
    complete_run;
  end
endmodule
